/* File: fcraq_consts.vh */
/*
 * Constants shared by the flash command controller and its bus-cycle engine:
 * bus register map, field positions, op codes, flash command bytes and
 * strobe timing.
 * Assumes a 100 MHz clock and a 16-bit parallel NOR flash with a byte-mode pin.
 */
`ifndef FCRAQ_CONSTS_VH
`define FCRAQ_CONSTS_VH

// ****************************************************************
// clock and timing
// ****************************************************************
`define FCRAQ_CLK_NS        10
`define FCRAQ_CYC_UP(ns)    (((ns) + `FCRAQ_CLK_NS - 1) / `FCRAQ_CLK_NS)
`define FCRAQ_T_AS_NS       10
`define FCRAQ_T_WP_NS       40
`define FCRAQ_T_WPH_NS      30
`define FCRAQ_T_ACC_NS      70
`define FCRAQ_T_OEH_NS      20
`define FCRAQ_SYNC_CYC      2

// ****************************************************************
// register map (byte offsets)
// ****************************************************************
`define FCRAQ_OFF_CTRL      12'h000
`define FCRAQ_OFF_ADDR      12'h004
`define FCRAQ_OFF_WDATA     12'h008
`define FCRAQ_OFF_RDATA     12'h00C
`define FCRAQ_OFF_STATUS    12'h010

// ****************************************************************
// fields
// ****************************************************************
`define FCRAQ_CTRL_OP_MSB   2
`define FCRAQ_CTRL_BYTE     8
`define FCRAQ_ST_BUSY       0
`define FCRAQ_ST_RDY        1
`define FCRAQ_ST_REFUSED    2
`define FCRAQ_ST_MODE_LSB   4
`define FCRAQ_ST_MODE_MSB   5

// ****************************************************************
// op codes and host view of device mode
// ****************************************************************
`define FCRAQ_OP_NONE       3'h0
`define FCRAQ_OP_RESET      3'h1
`define FCRAQ_OP_AUTOSEL    3'h2
`define FCRAQ_OP_QUERY      3'h3
`define FCRAQ_OP_WRITE      3'h4
`define FCRAQ_OP_READ       3'h5
`define FCRAQ_OP_QREAD      3'h6
`define FCRAQ_MODE_ARRAY    2'h0
`define FCRAQ_MODE_AUTOSEL  2'h1
`define FCRAQ_MODE_QUERY    2'h2

// ****************************************************************
// flash command bytes and word-mode command addresses
// ****************************************************************
`define FCRAQ_CMD_RESET     16'h00F0
`define FCRAQ_CMD_UNLOCK1   16'h00AA
`define FCRAQ_CMD_UNLOCK2   16'h0055
`define FCRAQ_CMD_AUTOSEL   16'h0090
`define FCRAQ_CMD_QUERY     16'h0098
`define FCRAQ_ADR_UNLOCK1   12'h555
`define FCRAQ_ADR_UNLOCK2   12'h2AA
`define FCRAQ_ADR_QUERY     12'h055
`define FCRAQ_ADR_LOW_W     12

`endif

/* File: fcraq_cycle.v */
/*
 * Single flash bus-cycle engine: one write or one read on the flash pins.
 * Assumes the flash latches address on the later falling edge and data on
 * the earlier rising edge of write strobe and chip select.
 */
`include "fcraq_consts.vh"

module fcraq_cycle #(
    parameter ADDR_W = 23
) (
    input  wire              clock,
    input  wire              resetn,
    input  wire              start,
    input  wire              wr,
    input  wire [ADDR_W-1:0] addr,
    input  wire [15:0]       wdata,
    output reg               done,
    output reg  [15:0]       rdata,
    output reg  [ADDR_W-1:0] flash_addr,
    input  wire [15:0]       flash_dq_in,
    output reg  [15:0]       flash_dq_out,
    output reg               flash_dq_oe_n,
    output reg               flash_ce_n,
    output reg               flash_we_n,
    output reg               flash_oe_n
);

    localparam [7:0] AS_CYC  = `FCRAQ_CYC_UP(`FCRAQ_T_AS_NS);
    localparam [7:0] WP_CYC  = `FCRAQ_CYC_UP(`FCRAQ_T_WP_NS);
    localparam [7:0] WPH_CYC = `FCRAQ_CYC_UP(`FCRAQ_T_WPH_NS);
    localparam [7:0] RD_CYC  = `FCRAQ_CYC_UP(`FCRAQ_T_ACC_NS) + `FCRAQ_SYNC_CYC;
    localparam [7:0] OEH_CYC = `FCRAQ_CYC_UP(`FCRAQ_T_OEH_NS);

    localparam [1:0] C_IDLE   = 2'h0;
    localparam [1:0] C_SETUP  = 2'h1;
    localparam [1:0] C_STROBE = 2'h2;
    localparam [1:0] C_HIGH   = 2'h3;

    reg [1:0]  state_q;
    reg [7:0]  cnt_q;
    reg        wr_q;
    reg [15:0] dq_m_q;
    reg [15:0] dq_s_q;

    // ****************************************************************
    // data pin synchroniser
    // ****************************************************************
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dq_m_q <= 16'h0000;
            dq_s_q <= 16'h0000;
        end else begin
            dq_m_q <= flash_dq_in;
            dq_s_q <= dq_m_q;
        end
    end

    // ****************************************************************
    // strobe sequencing
    // ****************************************************************
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q       <= C_IDLE;
            cnt_q         <= 8'h00;
            wr_q          <= 1'b0;
            done          <= 1'b0;
            rdata         <= 16'h0000;
            flash_addr    <= {ADDR_W{1'b0}};
            flash_dq_out  <= 16'h0000;
            flash_dq_oe_n <= 1'b1;
            flash_ce_n    <= 1'b1;
            flash_we_n    <= 1'b1;
            flash_oe_n    <= 1'b1;
        end else begin
            done <= 1'b0;
            case (state_q)
                C_IDLE: begin
                    if (start) begin
                        // address settles before either strobe falls
                        flash_addr    <= addr;
                        flash_dq_out  <= wdata;
                        flash_dq_oe_n <= ~wr;
                        wr_q          <= wr;
                        cnt_q         <= AS_CYC - 8'h01;
                        state_q       <= C_SETUP;
                    end
                end
                C_SETUP: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        flash_ce_n <= 1'b0;
                        flash_we_n <= ~wr_q;
                        flash_oe_n <= wr_q;
                        cnt_q      <= wr_q ? (WP_CYC - 8'h01) : (RD_CYC - 8'h01);
                        state_q    <= C_STROBE;
                    end
                end
                C_STROBE: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        // write strobe rises alone first; data held past it
                        flash_we_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        if (!wr_q) begin
                            rdata <= dq_s_q;
                        end
                        cnt_q   <= wr_q ? (WPH_CYC - 8'h01) : (OEH_CYC - 8'h01);
                        state_q <= C_HIGH;
                    end
                end
                default: begin
                    flash_ce_n <= 1'b1;
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        flash_dq_oe_n <= 1'b1;
                        done          <= 1'b1;
                        state_q       <= C_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

/* File: fcraq_ctrl.v */
/*
 * Host-side flash command controller: APB registers take an op from software
 * and turn it into the flash command sequence on the parallel flash pins.
 * Assumes an APB master on the same clock and a banked NOR flash outside.
 */
// Operation
// - host writes command cycles only in defined order; reset recovers
// - host writes reset on timeout flag or to leave identification mode
// - identification entry: two unlocks then bank address with command
// - no identification entry while another bank programs or erases
// - query entry: 98h to word 55h (byte AAh) when ready; reset leaves
`include "fcraq_consts.vh"

module fcraq_ctrl #(
    parameter ADDR_W = 23
) (
    input  wire              clock,
    input  wire              resetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    output wire [ADDR_W-1:0] flash_addr,
    input  wire [15:0]       flash_dq_in,
    output wire [15:0]       flash_dq_out,
    output wire              flash_dq_oe_n,
    output wire              flash_ce_n,
    output wire              flash_we_n,
    output wire              flash_oe_n,
    output reg               flash_byte_n,
    input  wire              ready_busy_out
);

    localparam [1:0] S_IDLE  = 2'h0;
    localparam [1:0] S_ISSUE = 2'h1;
    localparam [1:0] S_WAIT  = 2'h2;

    reg [1:0]        state_q;
    reg [2:0]        op_q;
    reg [1:0]        step_q;
    reg [1:0]        mode_q;
    reg [ADDR_W-1:0] addr_q;
    reg [15:0]       wdata_q;
    reg [15:0]       rdata_q;
    reg              refused_q;
    reg              rb_m_q;
    reg              rb_s_q;
    reg              start_q;
    reg              cyc_wr_q;
    reg [ADDR_W-1:0] cyc_addr_q;
    reg [15:0]       cyc_data_q;
    wire             cyc_done;
    wire [15:0]      cyc_rdata;

    wire             acc     = psel & penable & ~pready;
    wire             fin     = psel & penable & pready;
    wire             wr_ctrl = fin & pwrite & (paddr == `FCRAQ_OFF_CTRL);
    wire [2:0]       new_op  = pwdata[`FCRAQ_CTRL_OP_MSB:0];
    wire             busy    = (state_q != S_IDLE);
    wire             refuse_new;
    wire             take_new;

    // ****************************************************************
    // sequence tables
    // ****************************************************************
    function [1:0] seq_last;
        input [2:0] op;
        begin
            seq_last = (op == `FCRAQ_OP_AUTOSEL) ? 2'h2 : 2'h0;
        end
    endfunction

    function [15:0] seq_data;
        input [2:0]  op;
        input [1:0]  step;
        input [15:0] wd;
        begin
            if (op == `FCRAQ_OP_RESET) begin
                seq_data = `FCRAQ_CMD_RESET;
            end else if (op == `FCRAQ_OP_QUERY) begin
                seq_data = `FCRAQ_CMD_QUERY;
            end else if (op == `FCRAQ_OP_AUTOSEL) begin
                seq_data = (step == 2'h0) ? `FCRAQ_CMD_UNLOCK1 :
                           (step == 2'h1) ? `FCRAQ_CMD_UNLOCK2 : `FCRAQ_CMD_AUTOSEL;
            end else begin
                seq_data = wd;
            end
        end
    endfunction

    // word address of a command cycle; the caller doubles it in byte mode
    function [ADDR_W-1:0] seq_addr;
        input [2:0]        op;
        input [1:0]        step;
        input [ADDR_W-1:0] a;
        begin
            if (op == `FCRAQ_OP_RESET) begin
                seq_addr = {ADDR_W{1'b0}};
            end else if (op == `FCRAQ_OP_QUERY) begin
                seq_addr = {{(ADDR_W-`FCRAQ_ADR_LOW_W){1'b0}}, `FCRAQ_ADR_QUERY};
            end else if (op == `FCRAQ_OP_AUTOSEL) begin
                // bank bits ride on the third cycle only
                if (step == 2'h0) begin
                    seq_addr = {{(ADDR_W-`FCRAQ_ADR_LOW_W){1'b0}}, `FCRAQ_ADR_UNLOCK1};
                end else if (step == 2'h1) begin
                    seq_addr = {{(ADDR_W-`FCRAQ_ADR_LOW_W){1'b0}}, `FCRAQ_ADR_UNLOCK2};
                end else begin
                    seq_addr = {a[ADDR_W-1:`FCRAQ_ADR_LOW_W], `FCRAQ_ADR_UNLOCK1};
                end
            end else begin
                seq_addr = a;
            end
        end
    endfunction

    function [ADDR_W-1:0] to_pin;
        input [ADDR_W-1:0] a;
        input              byte_mode;
        begin
            to_pin = byte_mode ? {a[ADDR_W-2:0], 1'b0} : a;
        end
    endfunction

    // ****************************************************************
    // ready/busy synchroniser
    // ****************************************************************
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rb_m_q <= 1'b1;
            rb_s_q <= 1'b1;
        end else begin
            rb_m_q <= ready_busy_out;
            rb_s_q <= rb_m_q;
        end
    end

    // identification and query entry only while the flash reports ready
    assign refuse_new = busy |
                        (((new_op == `FCRAQ_OP_AUTOSEL) |
                          (new_op == `FCRAQ_OP_QUERY)) & ~rb_s_q);
    assign take_new   = wr_ctrl & (new_op != `FCRAQ_OP_NONE) & ~refuse_new;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            prdata       <= 32'h0000_0000;
            addr_q       <= {ADDR_W{1'b0}};
            wdata_q      <= 16'h0000;
            flash_byte_n <= 1'b1;
            refused_q    <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            // a fresh refusal outranks a clear in the same cycle
            refused_q <= (wr_ctrl & (new_op != `FCRAQ_OP_NONE) & refuse_new) |
                         (refused_q & ~(fin & pwrite & (paddr == `FCRAQ_OFF_STATUS) &
                                        pwdata[`FCRAQ_ST_REFUSED]));
            if (acc) begin
                if (paddr == `FCRAQ_OFF_CTRL) begin
                    prdata <= {23'h00_0000, ~flash_byte_n, 5'h00, op_q};
                end else if (paddr == `FCRAQ_OFF_ADDR) begin
                    prdata <= {{(32-ADDR_W){1'b0}}, addr_q};
                end else if (paddr == `FCRAQ_OFF_WDATA) begin
                    prdata <= {16'h0000, wdata_q};
                end else if (paddr == `FCRAQ_OFF_RDATA) begin
                    prdata <= {16'h0000, rdata_q};
                end else if (paddr == `FCRAQ_OFF_STATUS) begin
                    // ready/busy stays low after a timeout until a reset op
                    prdata <= {26'h000_0000, mode_q, 1'b0, refused_q,
                               rb_s_q, busy};
                end else begin
                    pslverr <= 1'b1;
                end
            end
            if (fin & pwrite) begin
                if ((paddr == `FCRAQ_OFF_CTRL) && !busy) begin
                    flash_byte_n <= ~pwdata[`FCRAQ_CTRL_BYTE];
                end else if (paddr == `FCRAQ_OFF_ADDR) begin
                    addr_q <= pwdata[ADDR_W-1:0];
                end else if (paddr == `FCRAQ_OFF_WDATA) begin
                    wdata_q <= pwdata[15:0];
                end
            end
        end
    end

    // ****************************************************************
    // command sequencer
    // ****************************************************************
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q    <= S_IDLE;
            op_q       <= `FCRAQ_OP_NONE;
            step_q     <= 2'h0;
            mode_q     <= `FCRAQ_MODE_ARRAY;
            rdata_q    <= 16'h0000;
            start_q    <= 1'b0;
            cyc_wr_q   <= 1'b0;
            cyc_addr_q <= {ADDR_W{1'b0}};
            cyc_data_q <= 16'h0000;
        end else begin
            start_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (take_new) begin
                        op_q    <= new_op;
                        step_q  <= 2'h0;
                        state_q <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    // fixed cycle order per op; never a partial sequence
                    start_q    <= 1'b1;
                    cyc_wr_q   <= (op_q != `FCRAQ_OP_READ) & (op_q != `FCRAQ_OP_QREAD);
                    cyc_data_q <= seq_data(op_q, step_q, wdata_q);
                    if ((op_q == `FCRAQ_OP_WRITE) || (op_q == `FCRAQ_OP_READ)) begin
                        cyc_addr_q <= addr_q;
                    end else begin
                        cyc_addr_q <= to_pin(seq_addr(op_q, step_q, addr_q), ~flash_byte_n);
                    end
                    state_q <= S_WAIT;
                end
                default: begin
                    if (cyc_done) begin
                        if (!cyc_wr_q) begin
                            rdata_q <= flash_byte_n ? cyc_rdata :
                                       {8'h00, cyc_rdata[7:0]};
                        end
                        if (step_q == seq_last(op_q)) begin
                            state_q <= S_IDLE;
                            if (op_q == `FCRAQ_OP_RESET) begin
                                mode_q <= `FCRAQ_MODE_ARRAY;
                            end else if (op_q == `FCRAQ_OP_AUTOSEL) begin
                                mode_q <= `FCRAQ_MODE_AUTOSEL;
                            end else if (op_q == `FCRAQ_OP_QUERY) begin
                                mode_q <= `FCRAQ_MODE_QUERY;
                            end
                        end else begin
                            step_q  <= step_q + 2'h1;
                            state_q <= S_ISSUE;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // pin cycle engine
    // ****************************************************************
    fcraq_cycle #(
        .ADDR_W        (ADDR_W)
    ) u_cycle (
        .clock         (clock),
        .resetn        (resetn),
        .start         (start_q),
        .wr            (cyc_wr_q),
        .addr          (cyc_addr_q),
        .wdata         (cyc_data_q),
        .done          (cyc_done),
        .rdata         (cyc_rdata),
        .flash_addr    (flash_addr),
        .flash_dq_in   (flash_dq_in),
        .flash_dq_out  (flash_dq_out),
        .flash_dq_oe_n (flash_dq_oe_n),
        .flash_ce_n    (flash_ce_n),
        .flash_we_n    (flash_we_n),
        .flash_oe_n    (flash_oe_n)
    );

endmodule

/* File: fcraq_checker.sv */
/* port checker for the flash command controller.
   assumes one clock domain; bound into fcraq_ctrl below. */
module fcraq_checker #(
    parameter ADDR_W = 23
) (
    input wire logic              clock,
    input wire logic              resetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [15:0]       flash_dq_out,
    input wire logic              flash_dq_oe_n,
    input wire logic              flash_ce_n,
    input wire logic              flash_we_n,
    input wire logic              flash_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // properties
    // ********
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence wr_low_s;
        !flash_we_n [*4] ##1 flash_we_n;
    endsequence
    sequence ce_late_s;
        !flash_ce_n ##1 flash_ce_n;
    endsequence
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle into access");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    pready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero while idle");
    we_width_a: assert property ($fell(flash_we_n) |-> wr_low_s)
        else $error("write strobe width wrong");
    we_framed_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n)
        else $error("write strobe without select or data");
    data_hold_a: assert property ($rose(flash_we_n) |-> $stable(flash_dq_out) && $stable(flash_addr))
        else $error("data or address moved at strobe rise");
    ce_late_a: assert property ($rose(flash_we_n) |-> ce_late_s)
        else $error("select not released one cycle after strobe");
endmodule
bind fcraq_ctrl fcraq_checker #(.ADDR_W(ADDR_W)) chk (.clock, .resetn, .psel, .penable, .prdata,
    .pready, .flash_addr, .flash_dq_out, .flash_dq_oe_n, .flash_ce_n, .flash_we_n, .flash_oe_n);

/* File: fcraq_flash_model.sv */
/* behavioural banked nor flash: command decode, id and query table.
   assumes strobes from the controller; hold_busy fakes an embedded op. */
module fcraq_flash_model #(
    parameter ADDR_W     = 23,
    parameter MAKER_CODE = 16'h00a5 // arbitrary value
) (
    input  wire logic [ADDR_W-1:0] flash_addr,
    input  wire logic [15:0]       flash_dq_out,
    input  wire logic              flash_dq_oe_n,
    input  wire logic              flash_ce_n,
    input  wire logic              flash_we_n,
    input  wire logic              flash_oe_n,
    input  wire logic              flash_byte_n,
    input  wire logic              hold_busy,
    output logic      [15:0]       flash_dq_in,
    output logic                   ready_busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // command latch and decode
    // ********
    localparam logic [223:0] PRI = 224'h5052_4931_330c_0201_0104_7700_0085_9501_0000_0000_0000_0004_1730_3017;
    logic [ADDR_W-1:0] la;
    logic [1:0]        mode;
    logic [1:0]        cnt;
    logic [15:0]       last;
    logic [15:0]       q;
    wire               w  = !flash_we_n && !flash_ce_n && flash_oe_n;
    wire               rd = !flash_ce_n && !flash_oe_n;
    wire [ADDR_W-1:0]  wa = flash_byte_n ? la : la >> 1;
    wire [ADDR_W-1:0]  ra = flash_byte_n ? flash_addr : flash_addr >> 1;
    initial begin
        mode = 2'h0;
        cnt = 2'h0;
        last = 16'h0000;
    end
    always @(posedge w) la = flash_addr;
    always @(negedge w) begin : cmd
        logic [15:0] d;
        d = flash_dq_oe_n ? 16'hxxxx : flash_dq_out;
        // busy bank ignores everything, reset included
        if (!hold_busy) begin
            if (d[7:0] == 8'hf0) begin
                mode = 2'h0;
                cnt = 2'h0;
            end else if (d[7:0] == 8'h98 && wa[7:0] == 8'h55) mode = 2'h2;
            else if (cnt == 2'h0 && d[7:0] == 8'haa && wa[11:0] == 12'h555) cnt = 2'h1;
            else if (cnt == 2'h1 && d[7:0] == 8'h55 && wa[11:0] == 12'h2aa) cnt = 2'h2;
            else if (cnt == 2'h2 && d[7:0] == 8'h90) begin
                mode = 2'h1;
                cnt = 2'h0;
            end else cnt = 2'h0;
        end
    end
    // ********
    // read path; released bus shows the inverse of the last value
    // ********
    always_comb begin
        if (mode == 2'h2 && ra[7:0] >= 8'h40 && ra[7:0] <= 8'h5b)
            q = {8'h00, PRI[8*(27-(ra[7:0]-8'h40)) +: 8]};
        else if (mode == 2'h2) q = 16'h0000;
        else if (mode == 2'h1) q = MAKER_CODE;
        else q = ~ra[15:0];
    end
    always @(negedge rd) last = q;
    assign flash_dq_in = rd ? q : ~last;
    assign ready_busy_out = !hold_busy;
endmodule

/* File: tb_top.sv */
/* self-checking bench for the flash command controller.
   assumes the behavioural flash model and the bound port checker. */
`include "fcraq_consts.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // harness
    // ********
    localparam logic [15:0]  MAKER = 16'h00a5; // arbitrary value
    localparam logic [223:0] PRI = 224'h5052_4931_330c_0201_0104_7700_0085_9501_0000_0000_0000_0004_1730_3017;
    logic clock, resetn, psel, penable, pwrite, pready, pslverr, errv, hold_busy;
    logic flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n, ready_busy_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [22:0] flash_addr;
    logic [15:0] flash_dq_in, flash_dq_out;
    int          n_errors, check_count;
    fcraq_ctrl #(.ADDR_W(23)) dut (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe_n,
        .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_byte_n, .ready_busy_out);
    fcraq_flash_model #(.ADDR_W(23), .MAKER_CODE(MAKER)) flash (.flash_addr, .flash_dq_out,
        .flash_dq_oe_n, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_byte_n, .hold_busy,
        .flash_dq_in, .ready_busy_out);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // op then poll status at most 50 times; busy still set after that is a mismatch
    task automatic run(input logic [31:0] c, input logic [22:0] a);
        apb(1'b1, `FCRAQ_OFF_ADDR, {9'h000, a});
        apb(1'b1, `FCRAQ_OFF_CTRL, c);
        rdv = 32'h0000_0001;
        for (int i = 0; i < 50 && rdv[0] !== 1'b0; i++) apb(1'b0, `FCRAQ_OFF_STATUS, 32'h0);
        `CHK("busy", 1'b0, rdv[0])
    endtask
    task automatic rd_array();
        run(32'h0000_0005, 23'h00_0123);
        apb(1'b0, `FCRAQ_OFF_RDATA, 32'h0);
        `CHK("array", 32'h0000_fedc, rdv)
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_idle();
        apb(1'b0, `FCRAQ_OFF_STATUS, 32'h0);
        `CHK("status", 6'h02, rdv[5:0])
        apb(1'b0, 12'h014, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {errv, rdv})
        rd_array();
        $display("test idle done");
    endtask
    task automatic t_query(input logic bm);
        logic [31:0] m;
        m = {23'h00_0000, bm, 8'h00};
        run(m | 32'h0000_0003, 23'h00_0000);
        apb(1'b0, `FCRAQ_OFF_STATUS, 32'h0);
        `CHK("mode", 2'h2, rdv[5:4])
        for (int i = 0; i < 28; i++) if (i < 17 || i > 22) begin
            run(m | 32'h0000_0006, 23'(8'h40 + i));
            apb(1'b0, `FCRAQ_OFF_RDATA, 32'h0);
            `CHK("table", {24'h00_0000, PRI[8*(27-i) +: 8]}, rdv)
        end
        run(32'h0000_0001, 23'h7f_ffff);
        apb(1'b0, `FCRAQ_OFF_STATUS, 32'h0);
        `CHK("mode", 2'h0, rdv[5:4])
        rd_array();
        $display("test query done");
    endtask
    task automatic t_autosel();
        run(32'h0000_0002, 23'h40_0000);
        apb(1'b0, `FCRAQ_OFF_STATUS, 32'h0);
        `CHK("mode", 2'h1, rdv[5:4])
        for (int i = 2; i < 4; i++) begin
            run(32'h0000_0005, 23'h40_0000 + 23'(i));
            apb(1'b0, `FCRAQ_OFF_RDATA, 32'h0);
            `CHK("code", {16'h0000, MAKER}, rdv)
        end
        // raw write of the reset byte leaves identification too
        apb(1'b1, `FCRAQ_OFF_WDATA, 32'h0000_00f0);
        run(32'h0000_0004, 23'h12_3456);
        rd_array();
        run(32'h0000_0001, 23'h00_0000);
        rd_array();
        $display("test autoselect done");
    endtask
    task automatic t_refuse();
        hold_busy <= 1'b1;
        repeat (4) @(posedge clock);
        for (int op = 2; op < 4; op++) begin
            run(32'(op), 23'h00_0000);
            apb(1'b0, `FCRAQ_OFF_STATUS, 32'h0);
            `CHK("refused", 6'h04, rdv[5:0])
            apb(1'b1, `FCRAQ_OFF_STATUS, 32'h0000_0004);
        end
        hold_busy <= 1'b0;
        repeat (4) @(posedge clock);
        apb(1'b0, `FCRAQ_OFF_STATUS, 32'h0);
        `CHK("cleared", 6'h02, rdv[5:0])
        $display("test refuse done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        $display("timeout waiting for the controller");
        finish_test();
    end
    initial begin
        {resetn, psel, penable, pwrite, hold_busy} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        n_errors = 0;
        check_count = 0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        t_idle();
        t_query(1'b0);
        t_query(1'b1);
        t_autosel();
        t_refuse();
        finish_test();
    end
endmodule
